// File: latch_readback_consts.vh
// constants for the count latch and readback logic
// assumes a 32-bit classic wishbone bus with byte data in bits 7:0
`ifndef LATCH_READBACK_CONSTS_VH
`define LATCH_READBACK_CONSTS_VH

// word byte addresses of the counter locations and the control location
`define ADDR_COUNTER0 8'h00
`define ADDR_COUNTER1 8'h04
`define ADDR_COUNTER2 8'h08
`define ADDR_CONTROL 8'h0c
`define ADDR_WIDTH 8

// control byte fields
`define CTL_SELECT_HI 7
`define CTL_SELECT_LO 6
`define CTL_FORMAT_HI 5
`define CTL_FORMAT_LO 4
`define CTL_MODE_HI 3
`define CTL_MODE_LO 1
`define CTL_DECIMAL 0

// readback command fields
`define RB_COUNT_LATCH_N 5
`define RB_STATUS_LATCH_N 4
`define RB_PICK_BASE 1
`define RB_SELECT_CODE 2'h3

// access formats
`define FMT_LATCH 2'h0
`define FMT_LOW 2'h1
`define FMT_HIGH 2'h2
`define FMT_PAIR 2'h3

// reset values
`define RST_FORMAT 2'h3
`define RST_MODE 3'h0
`define RST_DECIMAL 1'h0
`define RST_HOLD 16'h0000
`define RST_NULL_COUNT 1'h1
`define RST_BYTE 8'h00

// unmapped reads answer this
`define UNMAPPED_DATA 32'h00000000

`endif

// File: counter_latch_readback.v
// count latch, byte sequencing and readback logic for three 16-bit counters
// assumes a counting core beside it that supplies live counts, output levels
// and a pulse when a written count has been moved into its working counter
//
// The register offsets and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`include "latch_readback_consts.vh"

module counter_latch_readback (
  input wire clk_i, // 25 mhz system clock
  input wire rst_i, // synchronous reset, active high
  input wire wb_cyc_i, // wishbone cycle
  input wire wb_stb_i, // wishbone strobe
  input wire wb_we_i, // wishbone write enable
  input wire [7:0] wb_adr_i, // wishbone byte address
  input wire [3:0] wb_sel_i, // wishbone byte selects
  input wire [31:0] wb_dat_i, // wishbone write data
  output reg [31:0] wb_dat_o, // wishbone read data
  output reg wb_ack_o, // wishbone acknowledge
  input wire [15:0] live_count0_i, // live count of counter 0
  input wire [15:0] live_count1_i, // live count of counter 1
  input wire [15:0] live_count2_i, // live count of counter 2
  input wire [2:0] out_level_i, // live output levels, bit n for counter n
  input wire [2:0] count_loaded_i, // pulse: written count moved into counter n
  output reg [47:0] load_value_o, // assembled count, 16 bits per counter
  output reg [2:0] load_strobe_o, // pulse: new count for counter n complete
  output reg [2:0] program_strobe_o, // pulse: counter n reprogrammed
  output reg [8:0] mode_o, // mode, 3 bits per counter
  output reg [2:0] decimal_o, // decimal counting flag per counter
  output reg [5:0] format_o // access format, 2 bits per counter
);

  // location decode, used by the bus front end and by every counter slice
  function [2:0] counter_hit;
    input [7:0] adr;
    begin
      if (adr == `ADDR_COUNTER0) begin
        counter_hit = 3'h1;
      end else if (adr == `ADDR_COUNTER1) begin
        counter_hit = 3'h2;
      end else if (adr == `ADDR_COUNTER2) begin
        counter_hit = 3'h4;
      end else begin
        counter_hit = 3'h0;
      end
    end
  endfunction

  // byte picked from a 16-bit value by format and the byte order toggle
  // in pair format the read toggle chooses the half
  function [7:0] pick_byte;
    input [1:0] fmt;
    input hi_next;
    input [15:0] value;
    begin
      if (fmt == `FMT_HIGH) begin
        pick_byte = value[15:8];
      end else if (fmt == `FMT_PAIR && hi_next) begin
        pick_byte = value[15:8];
      end else begin
        pick_byte = value[7:0];
      end
    end
  endfunction

  // count assembled from a written byte, as the access format places it
  function [15:0] assembled;
    input [1:0] fmt;
    input [7:0] data;
    input [7:0] low;
    begin
      if (fmt == `FMT_LOW) begin
        assembled = {8'h00, data};
      end else if (fmt == `FMT_HIGH) begin
        assembled = {data, 8'h00};
      end else begin
        assembled = {data, low};
      end
    end
  endfunction

  // a write completes a count unless it is the low half of a pair
  function load_done;
    input [1:0] fmt;
    input hi_next;
    begin
      load_done = (fmt != `FMT_PAIR) || hi_next;
    end
  endfunction

  wire request;
  wire commit;
  wire [2:0] hit;
  wire control_hit;
  wire [7:0] wbyte;
  wire wr_byte;
  wire is_readback;
  wire [47:0] live_all;
  wire [23:0] next_byte_all;
  wire ctl_wr;
  wire [1:0] ctl_select;
  wire [1:0] ctl_format;
  wire [2:0] rb_picks;
  wire rb_count;
  wire rb_status;
  // per-counter state gathered for the shared hand-off register
  wire [2:0] program_all;
  wire [2:0] wr_all;
  wire [2:0] wr_hi_all;
  wire [5:0] fmt_all;
  wire [8:0] mode_all;
  wire [2:0] bcd_all;
  wire [23:0] low_all;
  integer i;

  assign request = wb_cyc_i & wb_stb_i;
  // side effects happen on the edge where the master samples ack
  assign commit = request & wb_ack_o;
  assign hit = counter_hit(wb_adr_i);
  assign control_hit = (wb_adr_i == `ADDR_CONTROL);
  // unused bus lanes are ignored; only byte lane 0 carries data
  assign wbyte = wb_dat_i[7:0];
  assign wr_byte = commit & wb_we_i & wb_sel_i[0];
  assign is_readback = ({wbyte[`CTL_SELECT_HI], wbyte[`CTL_SELECT_LO]} == `RB_SELECT_CODE);
  assign live_all = {live_count2_i, live_count1_i, live_count0_i};
  // control byte fields, shared by every slice; both latch flags are active low
  assign ctl_wr = wr_byte & control_hit;
  assign ctl_select = {wbyte[`CTL_SELECT_HI], wbyte[`CTL_SELECT_LO]};
  assign ctl_format = {wbyte[`CTL_FORMAT_HI], wbyte[`CTL_FORMAT_LO]};
  assign rb_picks = wbyte[`RB_PICK_BASE +: 3];
  assign rb_count = ctl_wr & is_readback & ~wbyte[`RB_COUNT_LATCH_N];
  assign rb_status = ctl_wr & is_readback & ~wbyte[`RB_STATUS_LATCH_N];

  // one ack cycle per request; ack drops in the cycle after it was given
  // no wait states: the answer always comes one cycle after the request
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= request & ~wb_ack_o;
    end
  end

  // read data is captured with ack; held state cannot change before commit
  // so a read never sees its own side effects
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= `UNMAPPED_DATA;
    end else if (request & ~wb_ack_o) begin
      if (hit[0]) begin
        wb_dat_o <= {24'h000000, next_byte_all[7:0]};
      end else if (hit[1]) begin
        wb_dat_o <= {24'h000000, next_byte_all[15:8]};
      end else if (hit[2]) begin
        wb_dat_o <= {24'h000000, next_byte_all[23:16]};
      end else begin
        // control location is write only; unmapped reads give zero
        wb_dat_o <= `UNMAPPED_DATA;
      end
    end
  end

  genvar n;
  generate
    // one slice per counter; the slices share the bus decode
    for (n = 0; n < 3; n = n + 1) begin : slice
      reg [1:0] fmt;
      reg [2:0] mode;
      reg bcd;
      // hold register and status latch, each with its own unread flag
      reg [15:0] hold;
      reg hold_valid;
      reg [7:0] status;
      reg status_valid;
      reg rd_hi;
      reg wr_hi;
      reg [7:0] low_part;
      reg null_count;
      reg [7:0] next_byte;

      wire [15:0] live;
      wire ctl_for_me;
      wire program_me;
      wire latch_me;
      wire status_me;
      wire rd_me;
      wire wr_me;
      wire [7:0] status_now;

      assign live = live_all[16*n +: 16];
      assign ctl_for_me = ctl_wr & ~is_readback & (ctl_select == n);
      assign program_me = ctl_for_me & (ctl_format != `FMT_LATCH);
      // a latch lands only while nothing is held
      // a readback latch and a single latch share the same hold register
      assign latch_me = ~hold_valid & ((ctl_for_me & (ctl_format == `FMT_LATCH)) |
        (rb_count & rb_picks[n]));
      assign status_me = ~status_valid & rb_status & rb_picks[n];
      assign rd_me = commit & ~wb_we_i & hit[n];
      assign wr_me = wr_byte & hit[n];
      assign status_now = {out_level_i[n], null_count, fmt, mode, bcd};

      // exported for the shared hand-off register and the read data mux
      assign program_all[n] = program_me;
      assign wr_all[n] = wr_me;
      assign wr_hi_all[n] = wr_hi;
      assign fmt_all[2*n +: 2] = fmt;
      assign mode_all[3*n +: 3] = mode;
      assign bcd_all[n] = bcd;
      assign low_all[8*n +: 8] = low_part;
      assign next_byte_all[8*n +: 8] = next_byte;

      // status first, then held count, then live count
      always @* begin
        next_byte = `RST_BYTE;
        if (status_valid) begin
          next_byte = status;
        end else if (hold_valid) begin
          next_byte = pick_byte(fmt, rd_hi, hold);
        end else begin
          next_byte = pick_byte(fmt, rd_hi, live);
        end
      end

      // configuration and read side latches
      always @(posedge clk_i) begin
        if (rst_i) begin
          fmt <= `RST_FORMAT;
          mode <= `RST_MODE;
          bcd <= `RST_DECIMAL;
          hold <= `RST_HOLD;
          hold_valid <= 1'b0;
          status <= `RST_BYTE;
          status_valid <= 1'b0;
          rd_hi <= 1'b0;
        end else if (program_me) begin
          // programming abandons a half-read pair and any unread latch
          fmt <= ctl_format;
          mode <= wbyte[`CTL_MODE_HI:`CTL_MODE_LO];
          bcd <= wbyte[`CTL_DECIMAL];
          rd_hi <= 1'b0;
          hold_valid <= 1'b0;
          status_valid <= 1'b0;
        end else begin
          if (latch_me) begin
            // copied whole, so a carry between the halves cannot tear it
            hold <= live;
            hold_valid <= 1'b1;
          end
          if (status_me) begin
            // frozen at the command; later output changes are not seen
            status <= status_now;
            status_valid <= 1'b1;
          end
          if (rd_me) begin
            if (status_valid) begin
              // a status read leaves the held count and the toggle alone
              status_valid <= 1'b0;
            end else begin
              if (fmt == `FMT_PAIR) begin
                rd_hi <= ~rd_hi;
              end
              // held data is released after its last byte
              if (hold_valid && (fmt != `FMT_PAIR || rd_hi)) begin
                hold_valid <= 1'b0;
              end
            end
          end
        end
      end

      // write side byte order, kept apart from the read toggle on purpose
      // so that a stray read cannot corrupt a half-written count
      always @(posedge clk_i) begin
        if (rst_i) begin
          wr_hi <= 1'b0;
          low_part <= `RST_BYTE;
        end else if (program_me) begin
          wr_hi <= 1'b0;
        end else if (wr_me && fmt == `FMT_PAIR) begin
          wr_hi <= ~wr_hi;
          if (!wr_hi) begin
            low_part <= wbyte;
          end
        end
      end

      // a new complete count waits for the core; set beats clear
      // limitation: a count written during the core's load stays flagged
      always @(posedge clk_i) begin
        if (rst_i) begin
          null_count <= `RST_NULL_COUNT;
        end else if (program_me || (wr_me && load_done(fmt, wr_hi))) begin
          null_count <= 1'b1;
        end else if (count_loaded_i[n]) begin
          null_count <= 1'b0;
        end
      end
    end
  endgenerate

  // count hand-off and configuration toward the counting core
  // copies run one cycle behind the slice registers; the core allows for it
  always @(posedge clk_i) begin
    if (rst_i) begin
      load_value_o <= {3{`RST_HOLD}};
      load_strobe_o <= 3'h0;
      program_strobe_o <= 3'h0;
      mode_o <= {3{`RST_MODE}};
      decimal_o <= {3{`RST_DECIMAL}};
      format_o <= {3{`RST_FORMAT}};
    end else begin
      program_strobe_o <= program_all;
      mode_o <= mode_all;
      decimal_o <= bcd_all;
      format_o <= fmt_all;
      // only a completed count reaches the core
      for (i = 0; i < 3; i = i + 1) begin
        load_strobe_o[i] <= 1'b0;
        if (wr_all[i] && !program_all[i] && load_done(fmt_all[2*i +: 2], wr_hi_all[i])) begin
          load_value_o[16*i +: 16] <=
            assembled(fmt_all[2*i +: 2], wbyte, low_all[8*i +: 8]);
          load_strobe_o[i] <= 1'b1;
        end
      end
    end
  end

endmodule // counter_latch_readback

// File: latch_readback_asserts.sv
// assertions on the bus and strobe ports of the latch and readback block
// assumes one classic wishbone master that writes with sel[0] set
`timescale 1ns/1ps
`include "latch_readback_consts.vh"
module latch_readback_asserts (
  input wire clk_i, // clock
  input wire rst_i, // sync reset
  input wire wb_cyc_i, // cycle
  input wire wb_stb_i, // strobe
  input wire wb_we_i, // write
  input wire [7:0] wb_adr_i, // address
  input wire [31:0] wb_dat_i, // write data
  input wire [31:0] wb_dat_o, // read data
  input wire wb_ack_o, // ack
  input wire [2:0] load_strobe_o, // count done
  input wire [2:0] program_strobe_o // programmed
);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire ctl = req && wb_we_i && wb_adr_i == `ADDR_CONTROL;
  wire [1:0] sel = wb_dat_i[7:6];
  wire [1:0] fmt = wb_dat_i[5:4];
  ack_one_cycle_a:
    assert property (req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle");
  high_bytes_zero_a:
    assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");
  unmapped_zero_a:
    assert property (req && !wb_we_i && (wb_adr_i[1:0] != 2'h0 || wb_adr_i > 8'h08)
      |=> wb_dat_o == `UNMAPPED_DATA) else $error("unmapped read not zero");
  program_pick_a:
    assert property (ctl && sel != 2'h3 && fmt != 2'h0
      |-> ##2 program_strobe_o == (3'h1 << $past(sel, 2))) else $error("wrong counter programmed");
  readback_no_program_a:
    assert property (ctl && sel == 2'h3 |-> ##2 program_strobe_o == 3'h0) else $error("readback programs");
  latch_no_program_a:
    assert property (ctl && fmt == 2'h0 |-> ##2 program_strobe_o == 3'h0) else $error("latch programs");
  read_no_strobe_a:
    assert property (req && !wb_we_i |-> ##2 (load_strobe_o | program_strobe_o) == 3'h0)
      else $error("read disturbs counter");
  strobe_from_write_a:
    assert property (|load_strobe_o |-> $past(wb_ack_o) && $past(wb_we_i) && $onehot(load_strobe_o))
      else $error("load strobe without write");
  cover property (ctl && sel == 2'h3);
  cover property (|load_strobe_o);
  cover property (req && !wb_we_i && wb_adr_i == `ADDR_COUNTER2);
endmodule // latch_readback_asserts
bind counter_latch_readback latch_readback_asserts chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .load_strobe_o(load_strobe_o), .program_strobe_o(program_strobe_o));

// File: test_counter_latch_readback.sv
// self-checking bench for the latch and readback block
// drives the wishbone port and the counting-core inputs itself
`timescale 1ns/1ps
`include "latch_readback_consts.vh"
module test_counter_latch_readback;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg req = 1'b0;
  reg we = 1'b0;
  reg [7:0] adr = 8'h00;
  reg [31:0] wdat = 32'h0;
  reg [47:0] live = 48'h0;
  reg [2:0] out_level_i = 3'h0;
  reg [2:0] count_loaded_i = 3'h0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o;
  wire [47:0] load_value_o;
  wire [2:0] load_strobe_o;
  wire [2:0] program_strobe_o;
  wire [8:0] mode_o;
  wire [2:0] decimal_o;
  wire [5:0] format_o;
  integer mismatches = 0;
  integer checks = 0;
  integer cycles = 0;
  integer seed = 32'h81c43ef0;
  integer n;
  reg [31:0] r;
  reg [47:0] e;
  reg [15:0] v;
  reg [7:0] a;
  reg [7:0] q;
  reg [7:0] cs [0:2];
  always #20 clk_i = ~clk_i;
  counter_latch_readback DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .live_count0_i(live[15:0]), .live_count1_i(live[31:16]),
    .live_count2_i(live[47:32]), .out_level_i(out_level_i), .count_loaded_i(count_loaded_i),
    .load_value_o(load_value_o), .load_strobe_o(load_strobe_o),
    .program_strobe_o(program_strobe_o), .mode_o(mode_o), .decimal_o(decimal_o),
    .format_o(format_o));
  function [7:0] stat(input o, input nc, input [7:0] c);
    stat = {o, nc, c[5:0]};
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task bus(input w, input [7:0] ad, input [7:0] d);
    begin
      @(posedge clk_i);
      req <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= {24'h0, d};
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      q = wb_dat_o[7:0];
      req <= 1'b0;
    end
  endtask
  task rd(input [7:0] ad, input [7:0] x);
    begin
      bus(1'b0, ad, 8'h00);
      check(q, x);
    end
  endtask
  task end_of_test;
    begin
      if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // the whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (cycles == 4000) begin
      mismatches = mismatches + 1;
      end_of_test;
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (n = 0; n < 3; n = n + 1) begin
      r = $random(seed);
      a = {4'h0, n[1:0], 2'h0};
      cs[n] = {n[1:0], 2'h3, r[3:1], n[0]};
      bus(1'b1, `ADDR_CONTROL, cs[n]);
      @(negedge clk_i);
      check(program_strobe_o, 3'h1 << n);
      bus(1'b1, a, r[23:16]);
      bus(1'b1, a, r[31:24]);
      @(negedge clk_i);
      check(load_strobe_o, 3'h1 << n);
      check(load_value_o[16*n +: 16], r[31:16]);
      check(mode_o[3*n +: 3], r[3:1]);
      check(decimal_o[n], n[0]);
      check(format_o[2*n +: 2], 2'h3);
      @(posedge clk_i);
      live[16*n +: 16] <= r[15:0];
      out_level_i <= r[6:4];
      // counter 2 never sees its count moved, so its null flag stays set
      count_loaded_i <= (n == 2) ? 3'h0 : 3'h1 << n;
      @(posedge clk_i);
      count_loaded_i <= 3'h0;
      bus(1'b1, `ADDR_CONTROL, {4'hc, 3'h1 << n, 1'b0});
      live <= ~live;
      rd(a, stat(r[4+n], n == 2, cs[n]));
      rd(a, r[7:0]);
      rd(a, r[15:8]);
    end
    r = $random(seed);
    e = {r[15:0], r};
    @(posedge clk_i);
    live <= e;
    bus(1'b1, `ADDR_CONTROL, 8'hde);
    live <= ~e;
    bus(1'b1, `ADDR_CONTROL, 8'h00);
    bus(1'b1, `ADDR_CONTROL, 8'he2);
    rd(`ADDR_COUNTER0, stat(out_level_i[0], 1'b0, cs[0]));
    for (n = 0; n < 3; n = n + 1) begin
      a = {4'h0, n[1:0], 2'h0};
      rd(a, e[16*n +: 8]);
      rd(a, e[16*n+8 +: 8]);
    end
    bus(1'b1, `ADDR_CONTROL, 8'h00);
    live <= e;
    rd(`ADDR_COUNTER0, ~e[7:0]);
    rd(`ADDR_COUNTER0, ~e[15:8]);
    for (n = 1; n < 3; n = n + 1) begin
      bus(1'b1, `ADDR_CONTROL, {2'h1, n[1:0], 4'h0});
      bus(1'b1, `ADDR_CONTROL, 8'h40);
      v = live[31:16];
      live <= ~live;
      rd(`ADDR_COUNTER1, n == 1 ? v[7:0] : v[15:8]);
    end
    @(posedge clk_i);
    rd(`ADDR_COUNTER1, live[31:24]);
    rd(8'h10, 8'h00);
    end_of_test;
  end
endmodule // test_counter_latch_readback
